// ### hw/bcl_map.svh
`ifndef BCL_MAP_SVH
`define BCL_MAP_SVH

// Register indices on the internal register port
`define BCL_ADDR_CTRL1 2'h0
`define BCL_ADDR_CTRL2 2'h1
`define BCL_ADDR_VOUT 2'h2
`define BCL_ADDR_STATUS 2'h3

// First control register fields
`define BCL_TON_HI 7
`define BCL_TON_LO 6
`define BCL_ILIM_HI 5
`define BCL_ILIM_LO 4
`define BCL_SWON_BIT 0

// Second control register fields
`define BCL_FPWM_BIT 6

// Status register fields
`define BCL_ST_PG_BIT 0
`define BCL_ST_HIC_BIT 1
`define BCL_ST_SSD_BIT 2
`define BCL_ST_LATCH_BIT 3

// Power-on defaults
`define BCL_CTRL1_RST 8'h01
`define BCL_CTRL2_RST 8'h00
`define BCL_VOUT_RST 8'h00

// Timing and fault counts
`define BCL_CLK_KHZ 10000
`define BCL_COOL_US 1000
`define BCL_OVL_MAX 3'h7
`define BCL_FAIL_MAX 2'h3

// Synchroniser bit positions
`define BCL_SY_TRIP 0
`define BCL_SY_LOW80 1
`define BCL_SY_TICK 2
`define BCL_SY_PWM 3
`define BCL_SY_VOK 4
`define BCL_SY_SSDONE 5
`define BCL_SY_SETTLED 6
`define BCL_SY_CHIPACT 7
`define BCL_SY_WIDTH 8

`endif

// ### hw/bcl_pkg.sv
package bcl_pkg;
    typedef enum logic [3:0] {
        BCL_OFF = 4'b0001,
        BCL_RUN = 4'b0010,
        BCL_COOL = 4'b0100,
        BCL_LATCH = 4'b1000
    } bcl_state_t;
endpackage

// ### hw/bcl_sync.sv
`timescale 1ns/1ps
module bcl_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic hold_r;
            // First stage feeds only the second one
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end else begin
                    meta_r <= async_in[i];
                    hold_r <= meta_r;
                end
            end
            assign sync_out[i] = hold_r;
        end
    endgenerate
endmodule

// ### hw/bcl_cool_timer.sv
`timescale 1ns/1ps
module bcl_cool_timer #(
    parameter int CYCLES = 10000
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic abort_in,
    output logic done_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_r;
    logic busy_r;
    logic done_r;
    wire last_w = busy_r && (cnt_r == '0);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= last_w && !abort_in;
            if (abort_in) begin
                busy_r <= 1'b0;
            end else if (start_in) begin
                busy_r <= 1'b1;
                cnt_r <= LOAD;
            end else if (last_w) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
    assign done_out = done_r;
endmodule

// ### hw/bcl_fault_seq.sv
// Contract
// - High-side trip: high off, low on
// - Hold low-side until current below 80%
// - Over seven overload cycles enters hiccup
// - Hiccup holds drives off for 1 ms
// - Failed restart repeats another cool-off wait
// - Fourth failed retry latches drives off
// - Hiccup flag high, startup-done low
// - Hiccup clears power-ok and pulls pin
// - Latch-off sets permanent shutdown flag
// - Current limit from two-bit control field
// - Power-up loads all register defaults
// - Registers survive enable low, used later
// - Only power cycle restores register defaults
// - Writes while disabled apply at enable
// - Lower voltage setting forces PWM mode
// - Power-good held during downward voltage step
// - Software turn-on toggle releases latch-off
// - Power-good after soft-start above threshold
`timescale 1ns/1ps
`include "bcl_map.svh"
module bcl_fault_seq
    import bcl_pkg::*;
#(
    parameter int COOL_CYCLES = (`BCL_COOL_US * `BCL_CLK_KHZ) / 1000
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hs_trip_in,
    input wire logic below_80pct_in,
    input wire logic cycle_start_in,
    input wire logic pwm_on_req_in,
    input wire logic vout_above_pg_in,
    input wire logic soft_start_done_in,
    input wire logic vout_settled_in,
    input wire logic chip_activate_pin_in,
    input wire logic reg_wr_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic hs_drive_out,
    output logic ls_drive_out,
    output logic soft_start_req_out,
    output logic power_ok_flag_out,
    output logic pgood_pin_out,
    output logic pgood_pin_oe_out,
    output logic overload_retry_flag_out,
    output logic startup_done_flag_out,
    output logic permanent_shutdown_flag_out,
    output logic [1:0] high_side_limit_sel_out,
    output logic [1:0] on_time_sel_out,
    output logic forced_pwm_out,
    output logic [7:0] ctrl2_out,
    output logic [7:0] vout_code_out
);
    logic [`BCL_SY_WIDTH-1:0] sy;
    bcl_state_t state_r, state_nxt;
    logic [7:0] ctrl1_r, ctrl2_r, vout_r, rdata_r;
    logic [2:0] ovl_cnt_r, ovl_cnt_nxt;
    logic [1:0] fail_cnt_r, fail_cnt_nxt;
    logic tick_d_r, trip_seen_r, limit_r, restarting_r, dvc_r, cool_done;
    logic hs_r, ls_r, ss_req_r, pg_r, hic_r, ssd_r, latch_r, fpwm_r, pg_oe_r;

    bcl_sync #(
        .WIDTH(`BCL_SY_WIDTH)
    ) u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({chip_activate_pin_in, vout_settled_in,
                   soft_start_done_in, vout_above_pg_in, pwm_on_req_in,
                   cycle_start_in, below_80pct_in, hs_trip_in}),
        .sync_out(sy)
    );

    wire trip_w = sy[`BCL_SY_TRIP];
    wire low80_w = sy[`BCL_SY_LOW80];
    wire pwm_w = sy[`BCL_SY_PWM];
    wire vok_w = sy[`BCL_SY_VOK];
    wire ssdone_w = sy[`BCL_SY_SSDONE];
    wire settled_w = sy[`BCL_SY_SETTLED];
    wire tick_w = sy[`BCL_SY_TICK] && !tick_d_r;
    // Either enable source going low is the release path
    wire enable_w = sy[`BCL_SY_CHIPACT] && ctrl1_r[`BCL_SWON_BIT];

    // Register decode
    wire wr_c1_w = reg_wr_in && (reg_addr_in == `BCL_ADDR_CTRL1);
    wire wr_c2_w = reg_wr_in && (reg_addr_in == `BCL_ADDR_CTRL2);
    wire wr_vo_w = reg_wr_in && (reg_addr_in == `BCL_ADDR_VOUT);
    wire wr_lower_w = wr_vo_w && (reg_wdata_in < vout_r);
    wire [7:0] status_w = {4'h0, latch_r, ssd_r, hic_r, pg_r};
    wire [7:0] rd_mux_w = (reg_addr_in == `BCL_ADDR_CTRL1) ? ctrl1_r :
                          (reg_addr_in == `BCL_ADDR_CTRL2) ? ctrl2_r :
                          (reg_addr_in == `BCL_ADDR_VOUT) ? vout_r :
                          status_w;

    // Fault sequencing terms
    wire in_run_w = (state_r == BCL_RUN);
    wire had_trip_w = trip_seen_r || trip_w;
    wire hic_evt_w = in_run_w && enable_w && tick_w && had_trip_w &&
                     (ovl_cnt_r == `BCL_OVL_MAX);
    wire latch_go_w = restarting_r && (fail_cnt_r == `BCL_FAIL_MAX);
    wire run_w = in_run_w && enable_w && !hic_evt_w;
    wire pg_good_w = run_w && ssdone_w && vok_w;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BCL_OFF: begin
                if (enable_w) begin
                    state_nxt = BCL_RUN;
                end
            end
            BCL_RUN: begin
                if (!enable_w) begin
                    state_nxt = BCL_OFF;
                end else if (hic_evt_w) begin
                    state_nxt = latch_go_w ? BCL_LATCH : BCL_COOL;
                end
            end
            BCL_COOL: begin
                if (!enable_w) begin
                    state_nxt = BCL_OFF;
                end else if (cool_done) begin
                    state_nxt = BCL_RUN;
                end
            end
            BCL_LATCH: begin
                if (!enable_w) begin
                    state_nxt = BCL_OFF;
                end
            end
            default: begin
                state_nxt = BCL_OFF;
            end
        endcase
    end

    always_comb begin
        ovl_cnt_nxt = ovl_cnt_r;
        if (!run_w) begin
            ovl_cnt_nxt = 3'h0;
        end else if (tick_w) begin
            ovl_cnt_nxt = had_trip_w ? ovl_cnt_r + 3'h1 : 3'h0;
        end
    end

    always_comb begin
        fail_cnt_nxt = fail_cnt_r;
        if (state_r == BCL_OFF) begin
            fail_cnt_nxt = 2'h0;
        end else if (hic_evt_w && restarting_r) begin
            fail_cnt_nxt = fail_cnt_r + 2'h1;
        end else if (pg_good_w) begin
            fail_cnt_nxt = 2'h0;
        end
    end

    wire limit_nxt = run_w && (trip_w || (limit_r && !low80_w));
    wire hs_nxt = run_w && pwm_w && !limit_nxt;
    wire ls_nxt = run_w && !hs_nxt;
    wire pg_nxt = !run_w ? 1'b0 : (dvc_r ? pg_r : pg_good_w);
    wire hic_nxt = hic_evt_w ||
                   (hic_r && state_r != BCL_OFF &&
                    !(pg_good_w && restarting_r));
    wire ssd_nxt = run_w &&
                   (ssd_r || pg_good_w || (ssdone_w && !restarting_r));
    wire dvc_nxt = wr_lower_w || (dvc_r && !settled_w);
    wire enter_run_w = (state_nxt == BCL_RUN) && !in_run_w;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= BCL_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // defaults load only at power-on reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl1_r <= `BCL_CTRL1_RST;
            ctrl2_r <= `BCL_CTRL2_RST;
            vout_r <= `BCL_VOUT_RST;
            rdata_r <= 8'h00;
        end else begin
            // writes accepted and kept in any state
            // settings written while disabled used at enable
            if (wr_c1_w) begin
                ctrl1_r <= reg_wdata_in;
            end
            if (wr_c2_w) begin
                ctrl2_r <= reg_wdata_in;
            end
            if (wr_vo_w) begin
                vout_r <= reg_wdata_in;
            end
            rdata_r <= rd_mux_w;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_d_r <= 1'b0;
            trip_seen_r <= 1'b0;
            ovl_cnt_r <= 3'h0;
            fail_cnt_r <= 2'h0;
            restarting_r <= 1'b0;
            limit_r <= 1'b0;
        end else begin
            tick_d_r <= sy[`BCL_SY_TICK];
            // A trip landing on the tick counts in the closing cycle
            trip_seen_r <= run_w && !tick_w && (trip_seen_r || trip_w);
            ovl_cnt_r <= ovl_cnt_nxt;
            fail_cnt_r <= fail_cnt_nxt;
            restarting_r <= (state_r == BCL_COOL && cool_done) ||
                            (restarting_r && state_r != BCL_OFF &&
                             !pg_good_w);
            limit_r <= limit_nxt;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hs_r <= 1'b0;
            ls_r <= 1'b0;
            ss_req_r <= 1'b0;
            pg_r <= 1'b0;
            pg_oe_r <= 1'b1;
            hic_r <= 1'b0;
            ssd_r <= 1'b0;
            latch_r <= 1'b0;
            dvc_r <= 1'b0;
            fpwm_r <= 1'b0;
        end else begin
            hs_r <= hs_nxt;
            ls_r <= ls_nxt;
            ss_req_r <= enter_run_w;
            pg_r <= pg_nxt;
            pg_oe_r <= !pg_nxt;
            hic_r <= hic_nxt;
            ssd_r <= ssd_nxt;
            latch_r <= (state_nxt == BCL_LATCH);
            dvc_r <= dvc_nxt;
            fpwm_r <= ctrl2_r[`BCL_FPWM_BIT] || dvc_nxt;
        end
    end

    bcl_cool_timer #(
        .CYCLES(COOL_CYCLES)
    ) u_cool (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(hic_evt_w && !latch_go_w),
        .abort_in(!enable_w),
        .done_out(cool_done)
    );

    assign reg_rdata_out = rdata_r;
    assign hs_drive_out = hs_r;
    assign ls_drive_out = ls_r;
    assign soft_start_req_out = ss_req_r;
    assign power_ok_flag_out = pg_r;
    // pin pulled low whenever power-ok is low
    assign pgood_pin_out = 1'b0;
    assign pgood_pin_oe_out = pg_oe_r;
    assign overload_retry_flag_out = hic_r;
    assign startup_done_flag_out = ssd_r;
    assign permanent_shutdown_flag_out = latch_r;
    assign high_side_limit_sel_out = ctrl1_r[`BCL_ILIM_HI:`BCL_ILIM_LO];
    assign on_time_sel_out = ctrl1_r[`BCL_TON_HI:`BCL_TON_LO];
    assign forced_pwm_out = fpwm_r;
    assign ctrl2_out = ctrl2_r;
    assign vout_code_out = vout_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_TRIP_HS_OFF: assert property (
        trip_w && run_w |=> !hs_drive_out && ls_drive_out)
        else $error("high side still on after trip");
    AST_LIMIT_HOLD: assert property (
        limit_r && !low80_w && !trip_w |=> !hs_drive_out)
        else $error("high side on before current fell");
    AST_HICCUP_ENTRY: assert property (
        hic_evt_w |=> state_r inside {BCL_COOL, BCL_LATCH} &&
                      overload_retry_flag_out)
        else $error("hiccup not entered");
    AST_COOL_DRIVES_OFF: assert property (
        state_r == BCL_COOL |=> !hs_drive_out && !ls_drive_out)
        else $error("drive active during cool-off");
    AST_COOL_NO_EARLY: assert property (
        $rose(state_r == BCL_COOL) |-> (state_r == BCL_COOL)[*8])
        else $error("cool-off ended early");
    AST_LATCH_STAYS: assert property (
        state_r == BCL_LATCH && enable_w |=> state_r == BCL_LATCH)
        else $error("latch-off left without release");
    AST_HIC_FLAGS: assert property (
        hic_evt_w |=> !startup_done_flag_out && !power_ok_flag_out &&
                      pgood_pin_oe_out)
        else $error("hiccup flags wrong");
    AST_LATCH_FLAG: assert property (
        $rose(state_r == BCL_LATCH) |-> permanent_shutdown_flag_out)
        else $error("shutdown flag not set");
    AST_FPWM_DOWN: assert property (
        wr_lower_w |=> ##1 forced_pwm_out)
        else $error("forced pwm missing on down step");
    AST_PG_BLANK: assert property (
        dvc_r && run_w |=> $stable(power_ok_flag_out))
        else $error("power-good moved while blanked");
    AST_RELEASE_CLEARS: assert property (
        state_r == BCL_OFF |=> fail_cnt_r == 2'h0 &&
                               !permanent_shutdown_flag_out)
        else $error("release left fault state");

    COV_HICCUP: cover property (hic_evt_w && !latch_go_w);
    COV_LATCH: cover property ($rose(state_r == BCL_LATCH));
    COV_RESTART: cover property (state_r == BCL_COOL && cool_done);
    COV_DVC: cover property (wr_lower_w && pg_r);
endmodule

// ### sim/bcl_stage_model.sv
`timescale 1ns/1ps
module bcl_stage_model #(
    parameter int SS_CYCLES = 30
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hs_drive_in,
    input wire logic ls_drive_in,
    input wire logic soft_start_req_in,
    input wire logic overload_cmd_in,
    input wire logic trip_cmd_in,
    input wire logic hold80_cmd_in,
    input wire logic dip_cmd_in,
    output logic hs_trip_out,
    output logic below_80pct_out,
    output logic cycle_start_out,
    output logic pwm_on_req_out,
    output logic soft_start_done_out,
    output logic vout_above_pg_out
);
    logic [2:0] phase_r;
    logic [7:0] ramp_r;
    logic [3:0] idle_r;
    wire both_off = !hs_drive_in && !ls_drive_in;
    // Output collapses once the stage sits idle, so no stale ramp survives
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_r <= 3'h0;
            ramp_r <= 8'h00;
            idle_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 3'h1;
            idle_r <= !both_off ? 4'h0 :
                      (idle_r == 4'hf) ? idle_r : idle_r + 4'h1;
            if (soft_start_req_in || idle_r == 4'hf) begin
                ramp_r <= 8'h00;
            end else if (ramp_r != 8'(SS_CYCLES)) begin
                ramp_r <= ramp_r + 8'h01;
            end
        end
    end
    assign hs_trip_out = overload_cmd_in | trip_cmd_in;
    // current stays above 80% while held
    assign below_80pct_out = !(hs_trip_out | hold80_cmd_in);
    assign cycle_start_out = !phase_r[2];
    assign pwm_on_req_out = phase_r < 3'h3;
    assign soft_start_done_out = ramp_r == 8'(SS_CYCLES);
    assign vout_above_pg_out = soft_start_done_out && !overload_cmd_in &&
                               !dip_cmd_in;
endmodule

// ### sim/buck_current_limit_fault_sequencer_test.sv
`timescale 1ns/1ps
module buck_current_limit_fault_sequencer_test;
    localparam int COOL = 20;
    logic clk_in = 0, sys_rst_in = 1, pin = 1, wr = 0, settled = 0;
    logic ovl = 0, trip = 0, hold80 = 0, dip = 0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, c1, c2, v;
    logic trip_s, b80, tick, pwmr, ssdone, vabove;
    logic hs, ls, ssr, pg, oe, hic, startup_done_flag, perm, fpwm, pin_o;
    logic [1:0] lim, on_time_sel;
    logic [7:0] rdata, c2o, vo;
    int mismatches = 0, checks_done = 0, ss_cnt = 0, k, n0;
    int unsigned seed;
    bit off_ok;
    bcl_fault_seq #(.COOL_CYCLES(COOL)) u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hs_trip_in(trip_s),
        .below_80pct_in(b80), .cycle_start_in(tick), .pwm_on_req_in(pwmr),
        .vout_above_pg_in(vabove), .soft_start_done_in(ssdone),
        .vout_settled_in(settled), .chip_activate_pin_in(pin),
        .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .hs_drive_out(hs), .ls_drive_out(ls),
        .soft_start_req_out(ssr), .power_ok_flag_out(pg),
        .pgood_pin_out(pin_o), .pgood_pin_oe_out(oe),
        .overload_retry_flag_out(hic), .startup_done_flag_out(startup_done_flag),
        .permanent_shutdown_flag_out(perm), .high_side_limit_sel_out(lim),
        .on_time_sel_out(on_time_sel), .forced_pwm_out(fpwm), .ctrl2_out(c2o),
        .vout_code_out(vo));
    bcl_stage_model u_stage (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hs_drive_in(hs),
        .ls_drive_in(ls), .soft_start_req_in(ssr), .overload_cmd_in(ovl),
        .trip_cmd_in(trip), .hold80_cmd_in(hold80), .dip_cmd_in(dip),
        .hs_trip_out(trip_s), .below_80pct_out(b80), .cycle_start_out(tick),
        .pwm_on_req_out(pwmr), .soft_start_done_out(ssdone),
        .vout_above_pg_out(vabove));
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) if (ssr === 1'b1) ss_cnt++;
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        wr = 1;
        addr = a;
        wdata = d;
        step(1);
        wr = 0;
        step(1);
    endtask
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
        addr = a;
        step(1);
        chk(rdata, exp);
    endtask
    task automatic wait_pg();
        for (k = 0; k < 200 && pg !== 1'b1; k++) step(1);
        chk(pg, 1);
    endtask
    task automatic defaults();
        chk({pin_o, hs, ls, oe, hic, perm}, 8'h04);
        rdchk(2'h0, 8'h01);
        rdchk(2'h1, 8'h00);
        rdchk(2'h2, 8'h00);
    endtask
    task automatic to_latch();
        n0 = ss_cnt;
        ovl = 1;
        for (k = 0; k < 1500 && perm !== 1'b1; k++) step(1);
        chk(perm, 1);
        chk(8'(ss_cnt - n0), 8'h04);
        step(40);
        chk({hs, ls, perm}, 8'h01);
        rdchk(2'h3, 8'h0a);
        chk(8'(ss_cnt - n0), 8'h04);
        ovl = 0;
    endtask
    task end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        mismatches++;
        end_sim();
    end
    initial begin
        seed = $urandom(32'hf4ee);
        repeat (20) @(posedge clk_in);
        #10;
        sys_rst_in = 0;
        defaults();
        pin = 0;
        step(30);
        c2 = 8'($urandom) & 8'hbf;
        v = 8'h80 | 8'($urandom);
        wreg(2'h1, c2);
        wreg(2'h2, v);
        wreg(2'h3, 8'hff);
        rdchk(2'h1, c2);
        pin = 1;
        wait_pg();
        chk({oe, startup_done_flag}, 8'h01);
        rdchk(2'h3, 8'h05);
        chk(c2o, c2);
        chk(vo, v);
        // Reconfigure only once soft-start is done
        for (int i = 0; i < 4; i++) begin
            c1 = {(i == 3) ? 2'h0 : 2'($urandom), 2'(i), 4'h1};
            wreg(2'h0, c1);
            chk(lim, 8'(i));
            chk(on_time_sel, c1[7:6]);
        end
        hold80 = 1;
        trip = 1;
        step(4);
        chk({hs, ls}, 8'h01);
        trip = 0;
        step(12);
        chk({hs, ls}, 8'h01);
        hold80 = 0;
        for (k = 0; k < 20 && hs !== 1'b1; k++) step(1);
        chk(hs, 1);
        // Short overload, under eight cycles, must not hiccup
        ovl = 1;
        step(48);
        ovl = 0;
        step(20);
        chk(hic, 0);
        n0 = ss_cnt;
        ovl = 1;
        for (k = 0; k < 120 && hic !== 1'b1; k++) step(1);
        chk(8'(k >= 56 && k <= 80), 1);
        chk({pin_o, hs, ls, pg, oe, startup_done_flag}, 8'h02);
        off_ok = 1;
        for (k = 0; k < 40 && ssr !== 1'b1; k++) begin
            off_ok &= !(hs | ls);
            step(1);
        end
        chk(8'(k >= COOL && k <= COOL + 3), 1);
        chk(off_ok, 1);
        for (k = 0; k < 400 && ss_cnt != n0 + 2; k++) step(1);
        chk(hic, 1);
        ovl = 0;
        wait_pg();
        chk({hic, startup_done_flag}, 8'h01);
        to_latch();
        wreg(2'h0, c1 & 8'hfe);
        wreg(2'h0, c1);
        chk(perm, 0);
        wait_pg();
        to_latch();
        pin = 0;
        step(4);
        pin = 1;
        step(4);
        chk(perm, 0);
        wait_pg();
        rdchk(2'h1, c2);
        rdchk(2'h2, v);
        wreg(2'h2, 8'hff);
        step(2);
        chk(fpwm, 0);
        wreg(2'h2, 8'hfe);
        step(2);
        chk(fpwm, 1);
        dip = 1;
        step(10);
        chk({pg, oe}, 8'h02);
        dip = 0;
        settled = 1;
        step(4);
        settled = 0;
        step(2);
        chk({fpwm, pg}, 8'h01);
        sys_rst_in = 1;
        step(2);
        sys_rst_in = 0;
        step(1);
        defaults();
        end_sim();
    end
endmodule
